// [logic/dra_cmd.v]
`timescale 1ns/10ps
`include "dra_map.vh"
module dra_cmd
(
	input wire clk_i, // system clock
	input wire nrst_i, // async reset, active low
	input wire rx_valid_i, // byte received from debug serial pin
	input wire [7:0] rx_data_i, // received byte
	output wire rx_ready_o, // byte accepted
	output wire tx_valid_o, // byte for debug serial pin
	output wire [7:0] tx_data_o, // byte to send
	input wire tx_take_i, // serializer took byte
	input wire debug_mode_i, // debug mode active
	input wire read_prot_i, // read-protect option enabled
	input wire [7:0] debugger_control_reg_i, // debugger control register
	input wire [15:0] pc_i, // current program counter
	output reg pc_load_o, // pulse: load program counter
	output reg [15:0] pc_data_o, // new program counter
	output reg rf_wr_o, // pulse: register file write
	output reg rf_rd_o, // pulse: register file read
	output reg [11:0] rf_addr_o, // register file address
	output reg [7:0] rf_wdata_o, // register write data
	output reg rf_side_eff_o, // read may apply read-clear effects
	input wire [7:0] rf_rdata_i // read data, valid cycle after rf_rd_o
);
	localparam ST_OP = 3'd0;
	localparam ST_PCH = 3'd1;
	localparam ST_PCL = 3'd2;
	localparam ST_AH = 3'd3;
	localparam ST_AL = 3'd4;
	localparam ST_SZ = 3'd5;
	localparam ST_WD = 3'd6;
	localparam ST_RD = 3'd7;

	reg [2:0] st_r;
	reg [7:0] op_r;
	reg [7:0] pch_r;
	reg [11:0] addr_r;
	reg [8:0] cnt_r;
	reg rd_wait_r;
	reg pc_lo_pend_r;
	reg [7:0] pc_lo_r;
	reg tx_load;
	reg [7:0] tx_byte;
	wire tx_busy;
	wire allow_rd;
	wire fctl_hit;
	wire [15:0] pc_rep;

	assign allow_rd = debug_mode_i & ~read_prot_i;
	assign pc_rep = allow_rd ? pc_i : `DRA_PROT_PC;
	assign fctl_hit = (addr_r >= `DRA_FCTL_BASE) &&
		(addr_r <= `DRA_FCTL_LAST);
	// incoming bytes are held off while a reply byte is still pending
	assign rx_ready_o = (st_r != ST_RD) && !pc_lo_pend_r && !tx_busy;

	dra_tx_hold u_tx
	(
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.load_i(tx_load),
		.data_i(tx_byte),
		.take_i(tx_take_i),
		.busy_o(tx_busy),
		.valid_o(tx_valid_o),
		.data_o(tx_data_o)
	);

	wire rx_go = rx_valid_i & rx_ready_o;

	always @*
	begin
		tx_load = 1'b0;
		tx_byte = 8'h00;
		if (rd_wait_r)
		begin
			tx_load = 1'b1;
			tx_byte = allow_rd ? rf_rdata_i : `DRA_PROT_BYTE;
		end
		else if (pc_lo_pend_r && !tx_busy)
		begin
			tx_load = 1'b1;
			tx_byte = pc_lo_r;
		end
		else if (rx_go && st_r == ST_OP)
		begin
			if (rx_data_i == `DRA_OP_RD_CTL)
			begin
				tx_load = 1'b1;
				tx_byte = debugger_control_reg_i;
			end
			else if (rx_data_i == `DRA_OP_RD_PC)
			begin
				tx_load = 1'b1;
				tx_byte = pc_rep[15:8];
			end
		end
	end

	reg [2:0] st_nxt;
	wire take_op;
	wire take_pch;
	wire take_pcl;
	wire take_ah;
	wire take_al;
	wire take_sz;
	wire take_wd;
	wire rd_idle;
	wire rd_issue;
	wire rd_last;
	wire step_byte;

	assign take_op = rx_go && (st_r == ST_OP);
	assign take_pch = rx_go && (st_r == ST_PCH);
	assign take_pcl = rx_go && (st_r == ST_PCL);
	assign take_ah = rx_go && (st_r == ST_AH);
	assign take_al = rx_go && (st_r == ST_AL);
	assign take_sz = rx_go && (st_r == ST_SZ);
	assign take_wd = rx_go && (st_r == ST_WD);
	// a read byte is fetched only when nothing is in flight toward the link,
	// so the reply path never needs more than the one holding stage
	assign rd_idle = (st_r == ST_RD) && !rf_rd_o && !rd_wait_r && !tx_busy;
	assign rd_issue = rd_idle && (cnt_r != 9'h000);
	assign rd_last = rd_idle && (cnt_r == 9'h000);
	assign step_byte = take_wd || rd_issue;

	always @*
	begin
		st_nxt = st_r;
		case (st_r)
		ST_OP:
			if (rx_go)
			begin
				case (rx_data_i)
				`DRA_OP_WR_PC: st_nxt = ST_PCH;
				`DRA_OP_WR_REG: st_nxt = ST_AH;
				`DRA_OP_RD_REG: st_nxt = ST_AH;
				default: st_nxt = ST_OP;
				endcase
			end
		ST_PCH:
			if (rx_go)
				st_nxt = ST_PCL;
		ST_PCL:
			if (rx_go)
				st_nxt = ST_OP;
		ST_AH:
			if (rx_go)
				st_nxt = ST_AL;
		ST_AL:
			if (rx_go)
				st_nxt = ST_SZ;
		ST_SZ:
			if (rx_go)
			begin
				if (op_r == `DRA_OP_WR_REG)
					st_nxt = ST_WD;
				else
					st_nxt = ST_RD;
			end
		ST_WD:
			// the last data byte ends the command
			if (rx_go && cnt_r == 9'h001)
				st_nxt = ST_OP;
		ST_RD:
			if (rd_last)
				st_nxt = ST_OP;
		default: st_nxt = ST_OP;
		endcase
	end

	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st_r <= ST_OP;
			op_r <= 8'h00;
		end
		else
		begin
			st_r <= st_nxt;
			if (take_op)
				op_r <= rx_data_i;
		end
	end

	// address wraps inside the 12-bit space
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			addr_r <= 12'h000;
		else if (take_ah)
			addr_r[11:8] <= rx_data_i[3:0];
		else if (take_al)
			addr_r[7:0] <= rx_data_i;
		else if (step_byte)
			addr_r <= addr_r + 12'h001;
	end

	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			cnt_r <= 9'h000;
		else if (take_sz)
		begin
			if (rx_data_i == 8'h00)
				cnt_r <= 9'h100;
			else
				cnt_r <= {1'b0, rx_data_i};
		end
		else if (step_byte)
			cnt_r <= cnt_r - 9'h001;
	end

	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pch_r <= 8'h00;
			pc_load_o <= 1'b0;
			pc_data_o <= `DRA_PC_RST;
		end
		else
		begin
			pc_load_o <= 1'b0;
			if (take_pch)
				pch_r <= rx_data_i;
			if (take_pcl)
			begin
				pc_data_o <= {pch_r, rx_data_i};
				// discarded bytes still complete the command
				pc_load_o <= allow_rd;
			end
		end
	end

	// low byte is captured with the high one so both halves match
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pc_lo_pend_r <= 1'b0;
			pc_lo_r <= 8'h00;
		end
		else if (take_op && rx_data_i == `DRA_OP_RD_PC)
		begin
			pc_lo_pend_r <= 1'b1;
			pc_lo_r <= pc_rep[7:0];
		end
		else if (tx_load && pc_lo_pend_r && !rd_wait_r)
			pc_lo_pend_r <= 1'b0;
	end

	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rf_wr_o <= 1'b0;
			rf_rd_o <= 1'b0;
			rf_addr_o <= 12'h000;
			rf_wdata_o <= 8'h00;
			rf_side_eff_o <= 1'b0;
		end
		else
		begin
			rf_wr_o <= 1'b0;
			rf_rd_o <= 1'b0;
			if (take_wd)
			begin
				rf_wr_o <= debug_mode_i & (~read_prot_i | fctl_hit);
				rf_addr_o <= addr_r;
				rf_wdata_o <= rx_data_i;
			end
			if (rd_issue)
			begin
				rf_rd_o <= allow_rd;
				rf_addr_o <= addr_r;
				rf_side_eff_o <= (addr_r == `DRA_WDT_ADDR);
			end
		end
	end

	// data is one cycle behind the strobe; a gated read skips the fetch
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rd_wait_r <= 1'b0;
		else if (rd_issue && !allow_rd)
			rd_wait_r <= 1'b1;
		else
			rd_wait_r <= rf_rd_o;
	end
endmodule // dra_cmd

// [logic/dra_map.vh]
`ifndef DRA_MAP_VH
`define DRA_MAP_VH
`define DRA_OP_RD_CTL 8'h05
`define DRA_OP_WR_PC 8'h06
`define DRA_OP_RD_PC 8'h07
`define DRA_OP_WR_REG 8'h08
`define DRA_OP_RD_REG 8'h09
`define DRA_PROT_BYTE 8'hff
`define DRA_PROT_PC 16'hffff
`define DRA_FCTL_BASE 12'hff8
`define DRA_FCTL_LAST 12'hffb
`define DRA_WDT_ADDR 12'hff0
`define DRA_PC_RST 16'h0000
`endif

// [logic/dra_tx_hold.v]
`timescale 1ns/10ps
// one-byte output holding stage toward the link serializer
module dra_tx_hold
(
	input wire clk_i, // system clock
	input wire nrst_i, // async reset, active low
	input wire load_i, // capture a byte
	input wire [7:0] data_i, // byte to send
	input wire take_i, // serializer accepts byte
	output wire busy_o, // byte still pending
	output wire valid_o, // byte available
	output reg [7:0] data_o // held byte
);
	reg full_r;
	assign busy_o = full_r & ~take_i;
	assign valid_o = full_r;
	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			full_r <= 1'b0;
			data_o <= 8'h00;
		end
		else if (load_i)
		begin
			full_r <= 1'b1;
			data_o <= data_i;
		end
		else if (take_i)
			full_r <= 1'b0;
	end
endmodule // dra_tx_hold

// [tb/dra_cmd_props.sv]
`timescale 1ns/10ps
module dra_cmd_props(input wire clk_i, nrst_i, rx_valid_i, rx_ready_o,
	tx_valid_o, tx_take_i, debug_mode_i, read_prot_i, pc_load_o, rf_wr_o,
	rf_rd_o, rf_side_eff_o, input wire [7:0] rx_data_i, tx_data_o,
	rf_wdata_o, rf_rdata_i, input wire [11:0] rf_addr_o,
	input wire [15:0] pc_data_o);
	wire ok = debug_mode_i & ~read_prot_i;
	wire tk = rx_valid_i & rx_ready_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	sequence rd_ans_s;
		##2 tx_valid_o && tx_data_o == $past(rf_rdata_i);
	endsequence
	pc_gate_a:
	assert property (pc_load_o |-> $past(ok) && $past(tk))
		else $error("pc load");
	wr_data_a:
	assert property (rf_wr_o |-> $past(tk) && rf_wdata_o == $past(rx_data_i))
		else $error("wr data");
	wr_gate_a:
	assert property (rf_wr_o |-> ok || debug_mode_i && rf_addr_o >= 12'hff8
		&& rf_addr_o <= 12'hffb) else $error("wr gate");
	rd_gate_a:
	assert property (rf_rd_o |-> ok) else $error("rd gate");
	side_eff_a:
	assert property (rf_rd_o |-> rf_side_eff_o == (rf_addr_o == 12'hff0))
		else $error("side effect");
	rd_data_a:
	assert property (rf_rd_o |-> rd_ans_s) else $error("rd data");
	tx_hold_a:
	assert property (tx_valid_o && !tx_take_i |=>
		tx_valid_o && $stable(tx_data_o)) else $error("tx hold");
	tx_block_a:
	assert property (tx_valid_o && !tx_take_i |-> !rx_ready_o)
		else $error("rx in tx");
endmodule // dra_cmd_props
bind dra_cmd dra_cmd_props dra_cmd_props_inst (.*);

// [tb/dra_host.sv]
`timescale 1ns/10ps
module dra_host(input wire clk_i, rx_ready_i, tx_valid_i,
	input wire [7:0] tx_data_i, output reg rx_valid_o = 0,
	output reg [7:0] rx_data_o = 0, output reg tx_take_o = 0);
	reg [1:0] d = 0;
	reg [7:0] got [$];
	integer n;
	// set when a byte is never accepted; the bench turns it into a mismatch
	reg stuck = 0;
	// varies the pace: 0 to 2 idle cycles before each reply byte is taken
	always @(posedge clk_i)
	begin
		d <= d + 2'h1;
		tx_take_o <= tx_valid_i & ~tx_take_o & d[1];
		if (tx_valid_i & ~tx_take_o & d[1])
			got.push_back(tx_data_i);
	end
	task send(input [7:0] b);
	begin
		@(posedge clk_i);
		rx_valid_o <= 1'b1;
		rx_data_o <= b;
		n = 0;
		do @(posedge clk_i); while (!rx_ready_i && ++n < 99);
		if (!rx_ready_i)
			stuck = 1'b1;
		rx_valid_o <= 1'b0;
		// stale byte shows inverted once released
		rx_data_o <= ~b;
	end
	endtask
endmodule // dra_host

// [tb/tb_dra_cmd.sv]
`timescale 1ns/10ps
module tb_dra_cmd;
	reg clk_i = 0, nrst_i = 0, dbg = 0, prot = 0, ok;
	reg [7:0] ctl = 0, rdata = 0, v;
	reg [11:0] a, w;
	reg [15:0] pc = 0;
	reg [31:0] s = 32'hbfb3;
	reg [7:0] rf [0:4095], m [0:4095];
	integer num_errors = 0, cmp_count = 0, i, j, k, n;
	wire rxv, rxr, txv, tk, pcl, wr, rd, se;
	wire [7:0] rxd, txd, wd;
	wire [11:0] ra;
	wire [15:0] pcd;
	always #5 clk_i = ~clk_i;
	dra_cmd dra_cmd_inst (.clk_i(clk_i), .nrst_i(nrst_i), .rx_valid_i(rxv),
		.rx_data_i(rxd), .rx_ready_o(rxr), .tx_valid_o(txv), .tx_data_o(txd),
		.tx_take_i(tk), .debug_mode_i(dbg), .read_prot_i(prot),
		.debugger_control_reg_i(ctl), .pc_i(pc), .pc_load_o(pcl),
		.pc_data_o(pcd), .rf_wr_o(wr), .rf_rd_o(rd), .rf_addr_o(ra),
		.rf_wdata_o(wd), .rf_side_eff_o(se), .rf_rdata_i(rdata));
	dra_host dra_host_inst (.clk_i(clk_i), .rx_ready_i(rxr), .tx_valid_i(txv),
		.tx_data_i(txd), .rx_valid_o(rxv), .rx_data_o(rxd), .tx_take_o(tk));
	// register file data is only good the cycle after the read strobe
	always @(posedge clk_i)
	begin
		rdata <= rd ? rf[ra] : ~rdata;
		if (wr) rf[ra] <= wd;
		if (pcl) pc <= pcd;
		if (rd)
		begin
			cmp_count++;
			if (se !== (ra == 12'hff0))
			begin
				$display("CHECK FAILED side_eff exp %b seen %b",
					ra == 12'hff0, se);
				num_errors++;
			end
		end
	end
	function [31:0] xs(input [31:0] x);
	begin
		x = x ^ x << 13;
		x = x ^ x >> 17;
		xs = x ^ x << 5;
	end
	endfunction
	task put(input [7:0] x);
	begin
		dra_host_inst.send(x);
		if (dra_host_inst.stuck)
		begin
			$display("CHECK FAILED rx_ready exp 1 seen 0");
			num_errors++;
			report_and_stop;
		end
	end
	endtask
	task hdr(input [7:0] op);
	begin
		put(op);
		put({4'h0, a[11:8]});
		put(a[7:0]);
		put(n[7:0]);
	end
	endtask
	task report_and_stop;
	begin
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask
	task chk(input [7:0] e);
	begin
		for (k = 0; dra_host_inst.got.size() == 0 && k < 999; k++)
			@(posedge clk_i);
		v = k < 999 ? dra_host_inst.got.pop_front() : 8'hxx;
		cmp_count++;
		if (v !== e)
		begin
			$display("CHECK FAILED reply exp %h seen %h", e, v);
			num_errors++;
		end
		if (k == 999) report_and_stop;
	end
	endtask
	initial
	begin
		for (i = 0; i < 4096; i++) {rf[i], m[i]} = {i[7:0], i[7:0]};
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		for (i = 0; i < 30; i++)
		begin
			s = xs(s);
			@(posedge clk_i);
			dbg <= s[0] | s[1];
			prot <= s[2] & s[3];
			ctl <= s[15:8];
			ok = (s[0] | s[1]) & ~(s[2] & s[3]);
			a = s[4] ? {8'hff, s[23:20]} : s[27:16];
			n = i == 5 ? 256 : s[6:5] + 1;
			case (i % 3)
			0: begin put(8'h05); chk(s[15:8]); end
			1:
			begin
				put(8'h06); put(s[23:16]); put(s[31:24]);
				repeat (3) @(posedge clk_i);
				put(8'h07);
				chk(ok ? s[23:16] : 8'hff);
				chk(ok ? s[31:24] : 8'hff);
			end
			default:
			begin
				hdr(8'h08);
				for (j = 0; j < n; j++)
				begin
					s = xs(s);
					w = a + j[11:0];
					put(s[7:0]);
					if (ok || dbg && w >= 12'hff8 && w <= 12'hffb) m[w] = s[7:0];
				end
				hdr(8'h09);
				for (j = 0; j < n; j++)
				begin
					w = a + j[11:0];
					chk(ok ? m[w] : 8'hff);
				end
			end
			endcase
		end
		report_and_stop;
	end
endmodule // tb_dra_cmd
